// *** hdl/cms_consts.svh ***
// Offsets, field positions, reset values and timing counts of the monitor
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH

// Configuration group
`define CMS_CFG0          6'h00
`define CMS_CFG1          6'h01
`define CMS_CFG2          6'h02
`define CMS_CFG3          6'h03
`define CMS_CFG4          6'h04
`define CMS_CFG5          6'h05
// Second status group
`define CMS_STB0          6'h08
`define CMS_STB1          6'h09
`define CMS_STB2          6'h0a
`define CMS_STB3          6'h0b
`define CMS_STB4          6'h0c
`define CMS_STB5          6'h0d
// Communication group base, six bytes
`define CMS_COMM_BASE     6'h10
`define CMS_COMM_LAST     6'h15
// Interrupt status and mask
`define CMS_IRQ_STAT      6'h18
`define CMS_IRQ_MASK      6'h19
// Field positions
`define CMS_REFERENCE_KEEP_ON_BIT     2
`define CMS_GPIO_LSB      3
`define CMS_REV_LSB       4
`define CMS_MUX_SELFTEST_FAIL_BIT   1
`define CMS_THERMAL_SHUTDOWN_FLAG_BIT      0
// Reset values
`define CMS_CFG0_RST      8'hf8
`define CMS_REV_VALUE     4'h1
// Timing
`define CMS_MIN_NS        60000000000
`define CMS_CLK_NS        4
`define CMS_HALF_MIN_CYC  (`CMS_MIN_NS / 2 / `CMS_CLK_NS)
`define CMS_WDT_NS        2000000000
`define CMS_WDT_CYC       (`CMS_WDT_NS / `CMS_CLK_NS)
`define CMS_UV_STEP       16
`endif

// *** hdl/cms_pkg.sv ***
// Types shared by the cell monitor register bank
package cms_pkg;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cms_req_t;
  typedef struct packed {
    logic [15:0] dsupply;
    logic [11:0] over;
    logic [11:0] under;
    logic        mux_selftest_fail;
    logic        thermal_shutdown_flag;
    logic        conv_busy;
  } cms_meas_t;
  typedef enum logic [1:0] {
    CMS_REF_OFF,
    CMS_REF_ON,
    CMS_REF_HOLD
  } cms_ref_t;
endpackage

// *** hdl/cms_regs.sv ***
// Register bank of the monitor: configuration, status group B, comm group
//
// Contract
// - GPIO write 0 enables pull-down, 1 disables
// - GPIO read returns sensed pin level
// - Reference on held until watchdog timeout
// - Reference off after conversions finish
// - Status bytes: supply, then cell flag pairs
// - Last status: revision, reserved, mux_selftest_fail, thermal
// - Comm group: three read-write two-byte slots
// - Even byte: leading nibble, data high
// - Odd byte: data low, trailing nibble
// - Mux self-test flag: 1 means failed
`include "cms_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cms_regs #(
  parameter longint WDT_CYC      = `CMS_WDT_CYC,     // Watchdog length
  parameter longint HALF_MIN_CYC = `CMS_HALF_MIN_CYC // Half minute
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire cms_pkg::cms_req_t  req,
  output logic [7:0]           rdata,
  input  wire cms_pkg::cms_meas_t meas,
  input  wire logic [4:0]      gpio_in,
  output logic [4:0]           gpio_pd_en,
  output logic                 ref_power,
  output logic [11:0]          discharge_sw,
  output logic [11:0]          under_thresh,
  output logic [11:0]          over_thresh,
  output logic [7:0]           xfer_slot [6],
  output logic                 irq
);
  import cms_pkg::*;

  // Pin synchroniser, two stages
  logic [4:0]  gpio_s1_reg, gpio_s2_reg;
  // Configuration state
  logic [7:0]  cfg_reg [6];
  logic [7:0]  cfg_next [6];
  // Comm staging bytes
  logic [7:0]  comm_reg [6];
  logic [7:0]  comm_next [6];
  // Read path
  logic [7:0]  rdata_next;
  // Interrupt status and mask
  logic [1:0]  ist_reg, ist_next, imask_reg, imask_next;
  logic [11:0] over_prev_reg, under_prev_reg;
  // Reference control
  cms_ref_t    ref_reg, ref_next;
  logic [31:0] wdt_reg, wdt_next;
  // Discharge timer, wide enough for the longest code at full clock
  logic [47:0] dct_reg, dct_next;
  logic [47:0] dct_len;
  logic        dct_run_reg, dct_run_next;
  logic        irq_next;
  logic [11:0] sw_next;

  wire logic [11:0] over_f  = meas.over;
  wire logic [11:0] under_f = meas.under;

  // Timeout lengths in half minutes per code
  function automatic logic [7:0] dct_halves(input logic [3:0] c);
    case (c)
      4'h1: dct_halves = 8'h01;
      4'h2: dct_halves = 8'h02;
      4'h3: dct_halves = 8'h04;
      4'h4: dct_halves = 8'h06;
      4'h5: dct_halves = 8'h08;
      4'h6: dct_halves = 8'h0a;
      4'h7: dct_halves = 8'h14;
      4'h8: dct_halves = 8'h1e;
      4'h9: dct_halves = 8'h28;
      4'ha: dct_halves = 8'h3c;
      4'hb: dct_halves = 8'h50;
      4'hc: dct_halves = 8'h78;
      4'hd: dct_halves = 8'h96;
      4'he: dct_halves = 8'hb4;
      4'hf: dct_halves = 8'hf0;
      default: dct_halves = 8'h00;
    endcase
  endfunction

  // Synchronise GPIO levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpio_s1_reg <= 5'h00;
      gpio_s2_reg <= 5'h00;
    end else begin
      gpio_s1_reg <= gpio_in;
      gpio_s2_reg <= gpio_s1_reg;
    end
  end

  // Register writes and read mux
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cfg_next[i]  = cfg_reg[i];
      comm_next[i] = comm_reg[i];
    end
    imask_next = imask_reg;
    rdata_next = 8'h00;
    if (req.wr) begin
      if (req.addr <= `CMS_CFG5) begin
        cfg_next[req.addr[2:0]] = req.wdata;
      end else if (req.addr >= `CMS_COMM_BASE &&
                   req.addr <= `CMS_COMM_LAST) begin
        comm_next[3'(req.addr - `CMS_COMM_BASE)] = req.wdata;
      end else if (req.addr == `CMS_IRQ_MASK) begin
        imask_next = req.wdata[1:0];
      end
    end
    if (req.rd) begin
      unique case (req.addr)
        `CMS_CFG0: rdata_next = {gpio_s2_reg, cfg_reg[0][2:0]};
        `CMS_CFG1: rdata_next = cfg_reg[1];
        `CMS_CFG2: rdata_next = cfg_reg[2];
        `CMS_CFG3: rdata_next = cfg_reg[3];
        `CMS_CFG4: rdata_next = cfg_reg[4];
        `CMS_CFG5: rdata_next = cfg_reg[5];
        `CMS_STB0: rdata_next = meas.dsupply[7:0];
        `CMS_STB1: rdata_next = meas.dsupply[15:8];
        `CMS_STB2: rdata_next = {over_f[3], under_f[3], over_f[2],
                                 under_f[2], over_f[1], under_f[1],
                                 over_f[0], under_f[0]};
        `CMS_STB3: rdata_next = {over_f[7], under_f[7], over_f[6],
                                 under_f[6], over_f[5], under_f[5],
                                 over_f[4], under_f[4]};
        `CMS_STB4: rdata_next = {over_f[11], under_f[11], over_f[10],
                                 under_f[10], over_f[9], under_f[9],
                                 over_f[8], under_f[8]};
        `CMS_STB5: rdata_next = {`CMS_REV_VALUE, 2'b00,
                                 meas.mux_selftest_fail, meas.thermal_shutdown_flag};
        `CMS_IRQ_STAT: rdata_next = {6'h00, ist_reg};
        `CMS_IRQ_MASK: rdata_next = {6'h00, imask_reg};
        default: begin
          if (req.addr >= `CMS_COMM_BASE && req.addr <= `CMS_COMM_LAST)
            rdata_next = comm_reg[3'(req.addr - `CMS_COMM_BASE)];
          else
            rdata_next = 8'h00; // Unmapped reads zero
        end
      endcase
    end
  end

  // Interrupt events: new cell flag, fault present; read clears, set wins
  always_comb begin
    ist_next = ist_reg;
    if (req.rd && req.addr == `CMS_IRQ_STAT)
      ist_next = 2'b00;
    if (|((over_f & ~over_prev_reg) | (under_f & ~under_prev_reg)))
      ist_next[0] = 1'b1;
    if (meas.thermal_shutdown_flag || meas.mux_selftest_fail)
      ist_next[1] = 1'b1;
    irq_next = |(ist_next & imask_next);
  end

  // Reference power sequencing
  always_comb begin
    ref_next = ref_reg;
    wdt_next = wdt_reg;
    unique case (ref_reg)
      CMS_REF_OFF: begin
        // A fresh keep-on write or a busy conversion wakes it, so expiry stays off
        if ((req.wr && req.addr == `CMS_CFG0 &&
             req.wdata[`CMS_REFERENCE_KEEP_ON_BIT]) || meas.conv_busy) begin
          ref_next = CMS_REF_ON;
          wdt_next = 32'(WDT_CYC);
        end
      end
      CMS_REF_ON: begin
        if (req.wr || req.rd)
          wdt_next = 32'(WDT_CYC); // Bus traffic kicks the watchdog
        else if (wdt_reg != 32'h0)
          wdt_next = wdt_reg - 32'h1;
        if (wdt_reg == 32'h0)
          ref_next = CMS_REF_OFF;
        else if (!cfg_reg[0][`CMS_REFERENCE_KEEP_ON_BIT])
          ref_next = CMS_REF_HOLD;
      end
      CMS_REF_HOLD: begin
        if (cfg_reg[0][`CMS_REFERENCE_KEEP_ON_BIT])
          ref_next = CMS_REF_ON;
        else if (!meas.conv_busy)
          ref_next = CMS_REF_OFF;
      end
    endcase
  end

  // Discharge timer and switches
  always_comb begin
    dct_len      = 48'(HALF_MIN_CYC) * 48'(dct_halves(cfg_reg[5][7:4]));
    dct_next     = dct_reg;
    dct_run_next = dct_run_reg;
    if (req.wr && req.addr == `CMS_CFG5) begin
      dct_next     = 48'h0; // Restart on a new code
      dct_run_next = 1'b1;
    end else if (cfg_reg[5][7:4] == 4'h0) begin
      dct_run_next = 1'b0;
    end else if (dct_run_reg) begin
      if (dct_reg >= dct_len)
        dct_run_next = 1'b0;
      else
        dct_next = dct_reg + 48'h1;
    end
    sw_next = {cfg_reg[5][3:0], cfg_reg[4]} &
              {12{dct_run_next}};
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) begin
        cfg_reg[i]  <= 8'h00;
        comm_reg[i] <= 8'hff;
      end
      cfg_reg[0]     <= `CMS_CFG0_RST;
      rdata          <= 8'h00;
      ist_reg        <= 2'b00;
      imask_reg      <= 2'b00;
      over_prev_reg  <= 12'h000;
      under_prev_reg <= 12'h000;
      ref_reg        <= CMS_REF_OFF;
      wdt_reg        <= 32'h0;
      dct_reg        <= 48'h0;
      dct_run_reg    <= 1'b0;
      irq            <= 1'b0;
      gpio_pd_en     <= 5'h00;
      ref_power      <= 1'b0;
      discharge_sw   <= 12'h000;
      under_thresh   <= 12'h000;
      over_thresh    <= 12'h000;
      for (int i = 0; i < 6; i++)
        xfer_slot[i] <= 8'hff;
    end else begin
      for (int i = 0; i < 6; i++) begin
        cfg_reg[i]   <= cfg_next[i];
        comm_reg[i]  <= comm_next[i];
        xfer_slot[i] <= comm_next[i];
      end
      rdata          <= rdata_next;
      ist_reg        <= ist_next;
      imask_reg      <= imask_next;
      over_prev_reg  <= over_f;
      under_prev_reg <= under_f;
      ref_reg        <= ref_next;
      wdt_reg        <= wdt_next;
      dct_reg        <= dct_next;
      dct_run_reg    <= dct_run_next;
      irq            <= irq_next;
      gpio_pd_en     <= ~cfg_next[0][7:3];
      ref_power      <= (ref_next != CMS_REF_OFF);
      discharge_sw   <= sw_next;
      // Threshold codes in units of 16 steps, under adds one
      under_thresh   <= {cfg_next[2][3:0], cfg_next[1]} + 12'h001;
      over_thresh    <= {cfg_next[3], cfg_next[2][7:4]};
    end
  end
endmodule
`default_nettype wire

// *** verif/cms_regs_checker.sv ***
// Assertion checker bound to the monitor register bank
`include "cms_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cms_regs_checker (
  input wire logic               clk,
  input wire logic               nrst,
  input wire cms_pkg::cms_req_t  req,
  input wire logic [7:0]         rdata,
  input wire cms_pkg::cms_meas_t meas,
  input wire logic [4:0]         gpio_in,
  input wire logic [4:0]         gpio_pd_en,
  input wire logic               ref_power,
  input wire logic [7:0]         xfer_slot [6]
);
  import cms_pkg::*;
  logic        rd_reg;   // Read taken at last edge
  logic [5:0]  a_reg;    // Its address
  logic [14:0] pin_reg;  // Last three pin samples
  // Over flag above under flag, per cell
  function automatic logic [7:0] pairs(input logic [3:0] o,
                                       input logic [3:0] u);
    for (int j = 0; j < 4; j++) pairs[2*j +: 2] = {o[j], u[j]};
  endfunction
  // Remember the read and the pin history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {rd_reg, a_reg, pin_reg} <= '0;
    end else begin
      {rd_reg, a_reg, pin_reg} <= {req.rd, req.addr, gpio_in, pin_reg[14:5]};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_rdata_idle: assert property (!rd_reg |-> rdata == 8'h00)
    else $error("Read data not zero outside a read");
  chk_supply_lo: assert property (rd_reg && a_reg == 6'h08 |->
    rdata == $past(meas.dsupply[7:0])) else $error("Supply low byte");
  chk_supply_hi: assert property (rd_reg && a_reg == 6'h09 |->
    rdata == $past(meas.dsupply[15:8])) else $error("Supply high byte");
  chk_cell_pairs: assert property (rd_reg && a_reg == 6'h0a |->
    rdata == pairs($past(meas.over[3:0]), $past(meas.under[3:0])))
    else $error("Cell flag pairs");
  chk_rev_byte: assert property (rd_reg && a_reg == 6'h0d |->
    rdata == {`CMS_REV_VALUE, 2'b00, $past(meas.mux_selftest_fail), $past(meas.thermal_shutdown_flag)})
    else $error("Revision and fault byte");
  chk_pull_down: assert property (req.wr && req.addr == 6'h00 |=>
    gpio_pd_en == ~$past(req.wdata[7:3])) else $error("Pull-down enables");
  chk_comm_write: assert property (req.wr && req.addr[5:3] == 3'b010 &&
    req.addr[2:1] != 2'b11 |=> xfer_slot[$past(req.addr[2:0])] ==
    $past(req.wdata)) else $error("Comm byte write");
  chk_ref_on: assert property (req.wr && req.addr == 6'h00 &&
    req.wdata[2] |-> ##[1:2] ref_power) else $error("Reference not on");
  chk_pin_read: assert property (rd_reg && a_reg == 6'h00 &&
    pin_reg == {3{gpio_in}} |-> rdata[7:3] == gpio_in)
    else $error("Pin level read");
  cover property (rd_reg && a_reg == 6'h0d);
  cover property (req.wr && req.addr == 6'h14);
  cover property (rd_reg && a_reg == 6'h00 && rdata[7:3] != 5'h00);
endmodule
bind cms_regs cms_regs_checker u_chk (.clk(clk), .nrst(nrst), .req(req),
  .rdata(rdata), .meas(meas), .gpio_in(gpio_in), .gpio_pd_en(gpio_pd_en),
  .ref_power(ref_power), .xfer_slot(xfer_slot));
`default_nettype wire

// *** verif/cms_host.sv ***
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module cms_host (
  input  wire logic             clk,
  output var cms_pkg::cms_req_t req,
  input  wire logic [7:0]       rdata
);
  import cms_pkg::*;
  initial req = '0;
  // One-cycle write, then address and data inverted
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  // One-cycle read, answer taken two edges after the request edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '{~a, 8'hff, 1'b0, 1'b0};
    @(posedge clk) d = rdata;
  endtask
  // Slot as leading nibble, data byte, trailing nibble
  task automatic slot(input int n, input logic [3:0] ic,
                      input logic [7:0] dt, input logic [3:0] fc);
    wr(6'(8'h10 + 2 * n), {ic, dt[7:4]});
    wr(6'(8'h11 + 2 * n), {dt[3:0], fc});
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the monitor register bank
`include "cms_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cms_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  cms_req_t   req;
  logic [7:0] rdata, d, xfer_slot [6];
  cms_meas_t  meas = '0;
  logic [4:0] gpio_in = 5'h00, gpio_pd_en;
  logic       ref_power, irq;
  logic [11:0] dsw, uth, oth; // Switches and thresholds
  int         err_count = 0, n_checks = 0, seed = 56282, ex, i, k;
  int         comm [6];  // Model of the comm bytes
  always #2 clk = ~clk;
  cms_regs #(.WDT_CYC(20), .HALF_MIN_CYC(10)) uut (.clk(clk), .nrst(nrst),
    .req(req), .rdata(rdata), .meas(meas), .gpio_in(gpio_in),
    .gpio_pd_en(gpio_pd_en), .ref_power(ref_power), .discharge_sw(dsw),
    .under_thresh(uth), .over_thresh(oth), .xfer_slot(xfer_slot),
    .irq(irq));
  cms_host host (.clk(clk), .req(req), .rdata(rdata));
  // Expected status byte from the present measurements
  function automatic int st(input int n);
    st = 0;
    if (n < 2) st = n ? meas.dsupply[15:8] : meas.dsupply[7:0];
    else if (n == 5) st = {`CMS_REV_VALUE, 2'b00, meas.mux_selftest_fail, meas.thermal_shutdown_flag};
    else for (int j = 0; j < 4; j++)
      st |= int'({meas.over[4*n-8+j], meas.under[4*n-8+j]}) << 2*j;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #40000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    cmp({2'b00, gpio_pd_en, ref_power}, 8'h00);
    // Comm reset values, then three random slots
    for (i = 0; i < 6; i++) begin
      host.rd(6'(16 + i), d);
      cmp(d, 8'hff);
    end
    for (i = 0; i < 3; i++) begin
      ex = $random(seed);
      host.slot(i, ex[3:0], ex[11:4], ex[15:12]);
      comm[2*i] = {ex[3:0], ex[11:8]};
      comm[2*i+1] = {ex[7:4], ex[15:12]};
    end
    for (i = 0; i < 6; i++) begin
      host.rd(6'(16 + i), d);
      cmp(d, 8'(comm[i]));
      cmp(xfer_slot[i], 8'(comm[i]));
    end
    // Thermal event, unmasked then masked
    for (k = 1; k >= 0; k--) begin
      host.wr(6'h19, 8'(2 * k));
      @(posedge clk) meas.thermal_shutdown_flag <= 1'b1;
      @(posedge clk) meas.thermal_shutdown_flag <= 1'b0;
      repeat (2) @(posedge clk);
      cmp({7'h00, irq}, 8'(k));
      host.rd(6'h18, d);
      cmp(d, 8'h02);
      repeat (2) @(posedge clk);
      cmp({7'h00, irq}, 8'h00);
    end
    // Pull-down writes and sensed pin reads
    repeat (4) begin
      ex = $random(seed);
      host.wr(6'h00, 8'(ex) & 8'hfb);
      @(posedge clk) gpio_in <= ex[12:8];
      cmp({3'h0, gpio_pd_en}, {3'h0, ~ex[7:3]});
      repeat (3) @(posedge clk);
      host.rd(6'h00, d);
      cmp(d, {ex[12:8], 1'b0, ex[1:0]});
    end
    // Keep-on, release, then watchdog expiry
    for (k = 0; k < 3; k++) begin
      host.wr(6'h00, k == 1 ? 8'h00 : 8'h04);
      repeat (k == 2 ? 40 : k + 2) @(posedge clk);
      cmp({7'h00, ref_power}, k == 0 ? 8'h01 : 8'h00);
    end
    // Threshold codes and timed balancing switches
    ex = $random(seed);
    host.wr(6'h01, ex[7:0]);
    host.wr(6'h02, ex[15:8]);
    host.wr(6'h03, ex[23:16]);
    host.wr(6'h04, ex[31:24]);
    host.wr(6'h05, 8'h1f);
    k = (ex[11:0] + 1) & 'hfff;
    repeat (2) @(posedge clk);
    cmp(uth[7:0], 8'(k));
    cmp({4'h0, uth[11:8]}, 8'(k >> 8));
    cmp(oth[7:0], {ex[19:16], ex[15:12]});
    cmp({4'h0, oth[11:8]}, {4'h0, ex[23:20]});
    cmp(dsw[7:0], ex[31:24]);
    cmp({4'h0, dsw[11:8]}, 8'h0f);
    repeat (22) @(posedge clk);
    cmp(dsw[7:0], 8'h00);
    cmp({4'h0, dsw[11:8]}, 8'h00);
    // Random measurements, status writes refused
    repeat (3) begin
      @(posedge clk) meas <= cms_meas_t'(43'({$random(seed), $random(seed)})
                                         & 43'h7fffffffffe);
      host.wr(6'h0d, 8'h55);
      for (i = 0; i < 6; i++) begin
        host.rd(6'(8 + i), d);
        cmp(d, 8'(st(i)));
      end
    end
    host.rd(6'h3f, d);
    cmp(d, 8'h00);
    wrap_up;
  end
endmodule
`default_nettype wire
